/* common/dpr_pkg.sv */
// Package with sizes, address layout and reset values for the dual-port transfer RAM
package dpr_pkg;
    // Capacity in bytes and derived word count
    localparam int unsigned RAM_BYTES = 2048;
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned LANE_BITS = 8;
    localparam int unsigned LANES = 2;
    localparam int unsigned WORDS = RAM_BYTES / LANES;
    localparam int unsigned WADDR_BITS = $clog2(WORDS);
    localparam int unsigned BADDR_BITS = WADDR_BITS + 1;
    // Data space is 64 Kbytes, byte addressed
    localparam int unsigned EA_BITS = 16;
    // Window sits at the top of the Y space; default base is a plain choice
    localparam logic [15:0] BASE_DEFAULT = 16'hf800;
    // Byte lane select bit position inside a byte address
    localparam int unsigned LANE_SEL_POS = 0;
    // Reset value of the read data outputs
    localparam logic [15:0] RDATA_RESET = 16'h0000;
endpackage

/* common/dpr_port_if.sv */
// Interface carrying one access port between the top and the storage array
`timescale 1ns/1ps
interface dpr_port_if #(
    parameter int unsigned AW = dpr_pkg::WADDR_BITS
);
    logic [AW-1:0] waddr; // Word address
    logic [1:0] we; // Per-lane write strobes
    logic [15:0] wdata; // Lane-placed write data
    logic re; // Read request
    logic [15:0] rdata; // Whole word read back
    modport master (output waddr, output we, output wdata, output re, input rdata);
    modport slave (input waddr, input we, input wdata, input re, output rdata);
endinterface

/* hdl/dpr_array.sv */
// Two-port byte-lane storage array with CPU write precedence
`timescale 1ns/1ps
module dpr_array #(
    parameter int unsigned WORDS = dpr_pkg::WORDS
) (
    input wire logic mclk,
    input wire logic clk_en,
    dpr_port_if.slave cpu,
    dpr_port_if.slave dma
);
    // Each lane owns its byte array, so no two processes ever write one variable
    genvar g;
    for (g = 0; g < 2; g++) begin : g_lane
        logic [7:0] mem [WORDS]; // Bytes of this lane
        logic [7:0] cpu_rd_q; // CPU read register, this lane
        logic [7:0] dma_rd_q; // DMA read register, this lane
        // Lane writes; same word and same lane: CPU takes precedence, DMA dropped
        always_ff @(posedge mclk) begin
            if (clk_en) begin
                if (dma.we[g] && !(cpu.we[g] && cpu.waddr == dma.waddr)) begin
                    mem[dma.waddr] <= dma.wdata[g*8 +: 8];
                end
                if (cpu.we[g]) begin
                    mem[cpu.waddr] <= cpu.wdata[g*8 +: 8];
                end
            end
        end
        // Independent read ports; neither ever waits on the other
        always_ff @(posedge mclk) begin
            if (clk_en) begin
                if (cpu.re) begin
                    cpu_rd_q <= mem[cpu.waddr];
                end
                if (dma.re) begin
                    dma_rd_q <= mem[dma.waddr];
                end
            end
        end
    end

    // Whole words: odd lane high, even lane low
    assign cpu.rdata = {g_lane[1].cpu_rd_q, g_lane[0].cpu_rd_q};
    assign dma.rdata = {g_lane[1].dma_rd_q, g_lane[0].dma_rd_q};
endmodule

/* hdl/dpr_ram.sv */
// Top of the dual-port transfer RAM: CPU data port and DMA port
`timescale 1ns/1ps
module dpr_ram #(
    parameter logic [15:0] BASE = dpr_pkg::BASE_DEFAULT, // Byte address of the window
    parameter int unsigned WORDS = dpr_pkg::WORDS // Word count of the array
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // CPU port, byte effective address
    input wire logic [15:0] cpu_ea,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic cpu_byte,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    output logic cpu_rvalid,
    output logic cpu_hit,
    // DMA port, byte offset inside the RAM
    input wire logic [dpr_pkg::BADDR_BITS-1:0] dma_addr,
    input wire logic dma_rd,
    input wire logic dma_wr,
    input wire logic dma_byte,
    input wire logic [15:0] dma_wdata,
    output logic [15:0] dma_rdata,
    output logic dma_rvalid,
    output logic dma_collide
);
    localparam int unsigned AW = $clog2(WORDS);
    localparam int unsigned BW = AW + 1;

    // Lane strobes from byte flag and address bit
    function automatic logic [1:0] lane_we(input logic wr, input logic bsel, input logic lsb);
        lane_we = !wr ? 2'h0 : (!bsel ? 2'h3 : (lsb ? 2'h2 : 2'h1));
    endfunction

    // Byte writes put the byte on the low data path; replicate it to both lanes
    function automatic logic [15:0] lane_data(input logic bsel, input logic [15:0] d);
        lane_data = bsel ? {d[7:0], d[7:0]} : d;
    endfunction

    dpr_port_if #(.AW(AW)) cpu_p ();
    dpr_port_if #(.AW(AW)) dma_p ();

    // Window decode: only addresses inside the top block reach the array
    logic [15:0] cpu_off; // Offset inside the window
    logic cpu_in; // CPU address falls in the window
    assign cpu_off = cpu_ea - BASE;
    assign cpu_in = (cpu_ea >= BASE) && (cpu_off < 16'(WORDS * 2));

    assign cpu_p.waddr = cpu_off[AW:1];
    assign cpu_p.we = lane_we(cpu_wr && cpu_in && clk_en, cpu_byte, cpu_ea[dpr_pkg::LANE_SEL_POS]);
    assign cpu_p.wdata = lane_data(cpu_byte, cpu_wdata);
    assign cpu_p.re = cpu_rd && cpu_in;

    // DMA path has no handshake with the CPU path, so it can never hold it off
    assign dma_p.waddr = dma_addr[BW-1:1];
    assign dma_p.we = lane_we(dma_wr && clk_en, dma_byte, dma_addr[dpr_pkg::LANE_SEL_POS]);
    assign dma_p.wdata = lane_data(dma_byte, dma_wdata);
    assign dma_p.re = dma_rd;

    dpr_array #(.WORDS(WORDS)) u_array (
        .mclk(mclk),
        .clk_en(clk_en),
        .cpu(cpu_p.slave),
        .dma(dma_p.slave)
    );

    // Remember byte/lane choice of the read in flight
    logic cpu_byte_q; // CPU read was a byte read
    logic cpu_lsb_q; // CPU lane picked
    logic dma_byte_q; // DMA read was a byte read
    logic dma_lsb_q; // DMA lane picked
    logic cpu_pend_q; // CPU read data arrives next cycle
    logic dma_pend_q; // DMA read data arrives next cycle
    logic cpu_pin_q; // Pending CPU read was inside the window

    // Read bookkeeping, one cycle from request to array data
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_pend_q <= 1'b0;
            dma_pend_q <= 1'b0;
            cpu_byte_q <= 1'b0;
            cpu_lsb_q <= 1'b0;
            dma_byte_q <= 1'b0;
            dma_lsb_q <= 1'b0;
            cpu_pin_q <= 1'b0;
        end else if (clk_en) begin
            cpu_pend_q <= cpu_rd;
            cpu_pin_q <= cpu_in;
            cpu_byte_q <= cpu_byte;
            cpu_lsb_q <= cpu_ea[dpr_pkg::LANE_SEL_POS];
            dma_pend_q <= dma_rd;
            dma_byte_q <= dma_byte;
            dma_lsb_q <= dma_addr[dpr_pkg::LANE_SEL_POS];
        end
    end

    // Registered CPU read answer; outside the window reads zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_rdata <= dpr_pkg::RDATA_RESET;
            cpu_rvalid <= 1'b0;
        end else if (clk_en) begin
            cpu_rvalid <= cpu_pend_q;
            if (cpu_pend_q) begin
                if (!cpu_pin_q) begin
                    cpu_rdata <= 16'h0000;
                end else if (cpu_byte_q) begin
                    // Byte lands on the low data path
                    cpu_rdata <= {8'h00, cpu_lsb_q ? cpu_p.rdata[15:8] : cpu_p.rdata[7:0]};
                end else begin
                    cpu_rdata <= cpu_p.rdata;
                end
            end
        end
    end

    // Registered DMA read answer
    always_ff @(posedge mclk) begin
        if (reset) begin
            dma_rdata <= dpr_pkg::RDATA_RESET;
            dma_rvalid <= 1'b0;
        end else if (clk_en) begin
            dma_rvalid <= dma_pend_q;
            if (dma_pend_q) begin
                dma_rdata <= dma_byte_q ? {8'h00, dma_lsb_q ? dma_p.rdata[15:8] : dma_p.rdata[7:0]}
                                        : dma_p.rdata;
            end
        end
    end

    // Status: CPU hit and dropped DMA write, registered one cycle late
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_hit <= 1'b0;
            dma_collide <= 1'b0;
        end else if (clk_en) begin
            cpu_hit <= (cpu_rd || cpu_wr) && cpu_in;
            dma_collide <= (cpu_p.waddr == dma_p.waddr) && |(cpu_p.we & dma_p.we);
        end
    end

    // Collision watch: a later DMA read of the word, before any other write, must show the CPU data
    logic [15:0] chk_cpu_q; // CPU data of a colliding full-word write
    logic [AW-1:0] chk_addr_q; // Its address
    logic chk_q; // Check armed
    always_ff @(posedge mclk) begin
        if (reset) begin
            chk_q <= 1'b0;
            chk_cpu_q <= 16'h0000;
            chk_addr_q <= '0;
        end else if (clk_en) begin
            if (cpu_p.we == 2'h3 && dma_p.we == 2'h3 && cpu_p.waddr == dma_p.waddr) begin
                chk_q <= 1'b1;
                chk_cpu_q <= cpu_p.wdata;
                chk_addr_q <= cpu_p.waddr;
            end else if ((|cpu_p.we) || (|dma_p.we)) begin
                // Any later write may change the word, so stop watching
                chk_q <= 1'b0;
            end
        end
    end

    a_cpu_wins: assert property (@(posedge mclk) disable iff (reset)
        chk_q && clk_en && dma_p.re && dma_p.waddr == chk_addr_q |=> dma_p.rdata == $past(chk_cpu_q))
        else $error("DMA write overtook CPU write on collision");

    a_collide_flag: assert property (@(posedge mclk) disable iff (reset)
        clk_en && cpu_p.waddr == dma_p.waddr && (cpu_p.we & dma_p.we) != 2'h0 |=> dma_collide)
        else $error("Collision not reported");

    a_cpu_latency: assert property (@(posedge mclk) disable iff (reset)
        clk_en && cpu_rd ##1 clk_en |=> cpu_rvalid)
        else $error("CPU read not answered in two cycles");

    a_outside_zero: assert property (@(posedge mclk) disable iff (reset)
        clk_en && cpu_rd && !cpu_in ##1 clk_en |=> cpu_rdata == 16'h0000)
        else $error("Read outside window not zero");

    a_byte_lane: assert property (@(posedge mclk) disable iff (reset)
        cpu_wr && cpu_byte && cpu_in && clk_en |-> $onehot(cpu_p.we))
        else $error("Byte write touched both lanes");

    a_dma_read: assert property (@(posedge mclk) disable iff (reset)
        clk_en && dma_rd ##1 clk_en |=> dma_rvalid)
        else $error("DMA read not answered in two cycles");
endmodule

/* dv/dpr_dma_model.sv */
// Behavioural DMA controller driving the transfer RAM's DMA port
`timescale 1ns/1ps
module dpr_dma_model (
    input wire logic mclk,
    output logic [dpr_pkg::BADDR_BITS-1:0] dma_addr,
    output logic dma_rd,
    output logic dma_wr,
    output logic dma_byte,
    output logic [15:0] dma_wdata,
    input wire logic [15:0] dma_rdata,
    input wire logic dma_rvalid
);
    // Idle at time zero
    initial begin
        {dma_addr, dma_rd, dma_wr, dma_byte, dma_wdata} = '0;
    end
    // One request held over one taking edge; released lines flip so stale data never passes
    task automatic req(input logic [dpr_pkg::BADDR_BITS-1:0] a, input logic w, input logic b, input logic [15:0] d);
        @(posedge mclk) #1;
        {dma_addr, dma_byte, dma_wdata, dma_wr, dma_rd} = {a, b, d, w, !w};
        @(posedge mclk) #1;
        {dma_addr, dma_wdata, dma_wr, dma_rd} = {~a, ~d, 2'b00};
    endtask
    // Read with a bounded wait for the answer
    task automatic rd(input logic [dpr_pkg::BADDR_BITS-1:0] a, output logic [15:0] q);
        int n;
        req(a, 1'b0, 1'b0, 16'h0000);
        n = 0;
        while (dma_rvalid !== 1'b1 && n < 6) begin
            @(posedge mclk) #1;
            n++;
        end
        q = dma_rdata;
    endtask
endmodule

/* dv/tb_dual_port_dma_ram.sv */
// Self-checking bench for the dual-port transfer RAM
`timescale 1ns/1ps
module tb_dual_port_dma_ram;
    localparam logic [15:0] B = dpr_pkg::BASE_DEFAULT; // Window base
    logic mclk = 0, reset = 1, clk_en = 1; // Clock enable dropped only by the freeze test
    logic cpu_rd = 0, cpu_wr = 0, cpu_byte = 0, cpu_rvalid, cpu_hit, dma_rd, dma_wr, dma_byte;
    logic dma_rvalid, dma_collide;
    logic [15:0] cpu_ea = 0, cpu_wdata = 0, cpu_rdata, dma_wdata, dma_rdata, q, r;
    logic [dpr_pkg::BADDR_BITS-1:0] dma_addr;
    int n_mismatch = 0, tests_run = 0, n0, n1;
    // Free-running 20 ns clock
    initial begin
        forever #10 mclk = ~mclk;
    end
    dpr_ram dut_u (.mclk(mclk), .reset(reset), .clk_en(clk_en), .cpu_ea(cpu_ea), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_byte(cpu_byte), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .cpu_hit(cpu_hit), .dma_addr(dma_addr), .dma_rd(dma_rd), .dma_wr(dma_wr),
        .dma_byte(dma_byte), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid),
        .dma_collide(dma_collide));
    dpr_dma_model dma_u (.mclk(mclk), .dma_addr(dma_addr), .dma_rd(dma_rd), .dma_wr(dma_wr),
        .dma_byte(dma_byte), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid));
    // Compare one value; case inequality so x never matches
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    // One CPU request over one taking edge, then lines flip
    task automatic cpu_req(input logic [15:0] a, input logic w, input logic b, input logic [15:0] d);
        @(posedge mclk) #1;
        {cpu_ea, cpu_byte, cpu_wdata, cpu_wr, cpu_rd} = {a, b, d, w, !w};
        @(posedge mclk) #1;
        {cpu_ea, cpu_wdata, cpu_wr, cpu_rd} = {~a, ~d, 2'b00};
    endtask
    // CPU read; n counts cycles to the answer
    task automatic cpu_get(input logic [15:0] a, input logic b, output logic [15:0] v, output int n);
        cpu_req(a, 1'b0, b, 16'h0000);
        n = 1;
        while (cpu_rvalid !== 1'b1 && n < 6) begin
            @(posedge mclk) #1;
            n++;
        end
        v = cpu_rdata;
    endtask
    // Outputs idle after reset
    task automatic t_reset();
        chk("cpu_rdata", 16'h0000, cpu_rdata);
        chk("dma_rdata", 16'h0000, dma_rdata);
        chk("flags", 16'h0000, {12'h000, cpu_rvalid, cpu_hit, dma_rvalid, dma_collide});
        $display("test reset done");
    endtask
    // Words cross between ports at both ends of the window
    task automatic t_word();
        cpu_req(B + 16'h07fe, 1'b1, 1'b0, 16'hbeef);
        dma_u.rd(11'h7fe, q);
        chk("dma top word", 16'hbeef, q);
        chk("dma_rvalid", 16'h0001, {15'h0000, dma_rvalid});
        dma_u.req(11'h000, 1'b1, 1'b0, 16'h1234);
        cpu_get(B, 1'b0, q, n0);
        chk("cpu base word", 16'h1234, q);
        chk("cpu_rvalid", 16'h0001, {15'h0000, cpu_rvalid});
        $display("test word done");
    endtask
    // Byte writes touch only their lane
    task automatic t_byte();
        cpu_req(B + 16'h0004, 1'b1, 1'b0, 16'haaaa);
        cpu_req(B + 16'h0005, 1'b1, 1'b1, 16'h0055);
        dma_u.req(11'h004, 1'b1, 1'b1, 16'h0033);
        dma_u.rd(11'h004, q);
        chk("lane merge", 16'h5533, q);
        cpu_get(B + 16'h0005, 1'b1, q, n0);
        chk("odd byte read", 16'h0055, q);
        $display("test byte done");
    endtask
    // Same word and lane written by both: CPU value kept, drop flagged
    task automatic t_collide();
        fork
            cpu_req(B + 16'h0010, 1'b1, 1'b0, 16'h1111);
            dma_u.req(11'h010, 1'b1, 1'b0, 16'h2222);
        join
        chk("dma_collide", 16'h0001, {15'h0000, dma_collide});
        dma_u.rd(11'h010, q);
        chk("collided word", 16'h1111, q);
        fork
            cpu_req(B + 16'h0012, 1'b1, 1'b1, 16'h0077);
            dma_u.req(11'h013, 1'b1, 1'b1, 16'h0088);
        join
        chk("lane split flag", 16'h0000, {15'h0000, dma_collide});
        cpu_get(B + 16'h0012, 1'b0, q, n0);
        chk("split lanes", 16'h8877, q);
        $display("test collide done");
    endtask
    // DMA traffic leaves CPU read latency unchanged
    task automatic t_parallel();
        cpu_get(B + 16'h0010, 1'b0, q, n0);
        fork
            cpu_get(B + 16'h0010, 1'b0, q, n1);
            dma_u.rd(11'h7fe, r);
        join
        chk("cpu latency", 16'(n0), 16'(n1));
        chk("cpu cycles", 16'h0002, 16'(n0));
        chk("cpu word", 16'h1111, q);
        chk("dma word", 16'hbeef, r);
        $display("test parallel done");
    endtask
    // Just below the window: write ignored, read zero, no hit
    task automatic t_window();
        cpu_req(B - 16'h0002, 1'b1, 1'b0, 16'hdead);
        chk("outside hit", 16'h0000, {15'h0000, cpu_hit});
        cpu_get(B - 16'h0002, 1'b0, q, n0);
        chk("outside read", 16'h0000, q);
        dma_u.rd(11'h7fe, q);
        chk("no alias", 16'hbeef, q);
        cpu_req(B + 16'h0020, 1'b1, 1'b0, 16'h0000);
        chk("inside hit", 16'h0001, {15'h0000, cpu_hit});
        $display("test window done");
    endtask
    // Clock enable low blocks both writes; a mid-run reset clears outputs but keeps contents
    task automatic t_freeze();
        cpu_req(B + 16'h0030, 1'b1, 1'b0, 16'h0f0f);
        @(posedge mclk) #1 clk_en = 0;
        cpu_req(B + 16'h0030, 1'b1, 1'b0, 16'h4444);
        dma_u.req(11'h030, 1'b1, 1'b0, 16'h5555);
        clk_en = 1;
        cpu_get(B + 16'h0030, 1'b0, q, n0);
        chk("frozen word", 16'h0f0f, q);
        @(posedge mclk) #1 reset = 1;
        repeat (2) @(posedge mclk);
        #1 reset = 0;
        t_reset();
        cpu_get(B + 16'h0030, 1'b0, q, n0);
        chk("kept word", 16'h0f0f, q);
        $display("test freeze done");
    endtask
    // Counts, verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the roughly 70 cycles the tests take
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        #1 reset = 0;
        t_reset();
        t_word();
        t_byte();
        t_collide();
        t_parallel();
        t_window();
        t_freeze();
        stop_test();
    end
endmodule
